// file: ewc_regs.svh
/*
  Register map, field positions, reset values and constants for the
  exposure window control block. Assumes a 32-bit APB with word-aligned
  byte addresses.
*/
`ifndef EWC_REGS_SVH
`define EWC_REGS_SVH
`define EWC_A_DISP 12'h000
`define EWC_A_ST_N 12'h004
`define EWC_A_ST_M 12'h008
`define EWC_A_SIZE 12'h00C
`define EWC_A_EXPM 12'h010
`define EWC_A_FLCM 12'h014
`define EWC_A_SPD 12'h018
`define EWC_A_GMAXL 12'h01C
`define EWC_A_GMAXH 12'h020
`define EWC_A_GMIN 12'h024
`define EWC_A_SHMAX 12'h028
`define EWC_A_SHSEL 12'h02C
`define EWC_A_BLC 12'h030
`define EWC_A_WGT 12'h034
`define EWC_A_PMASK 12'h038
`define EWC_A_PITCH 12'h03C
`define EWC_A_TGT 12'h040
`define EWC_A_STAT 12'h044
`define EWC_F_MK 0
`define EWC_F_FULL 4
`define EWC_F_WOUT 7
`define EWC_F_MANUAL_EXPOSURE_SELECT 0
`define EWC_F_BACKLIGHT_COMP_DISABLE 2
`define EWC_F_EXPOSURE_REFERENCE_SELECT 3
`define EWC_F_GSEL 4
`define EWC_F_SHUT 6
`define EWC_F_NFLC 0
`define EWC_F_LOW_SPEED_SHUTTER_LIMITER 1
`define EWC_F_BACKLIGHT_METHOD_SELECT 0
`define EWC_GRID_LAST 4'hE
`define EWC_SEL_A0 3'h1
`define EWC_SEL_A4 3'h5
`define EWC_RST_ZERO 8'h00
`define EWC_RST_A4 8'h55
`define EWC_RST_MAX 8'hFF
`define EWC_RST_SPD 8'h04
`define EWC_RST_PITCH 16'h1010
`define EWC_RST_TGT 8'h80
`endif

// file: ewc_pkg.sv
/*
  Types for the exposure window control block.
  Assumes ewc_regs.svh for the numeric constants.
*/
package ewc_pkg;
  typedef struct packed {
    logic [7:0] disp, stN, stM, size, expm, flcm, spd;
    logic [7:0] gMaxL, gMaxH, gMin, shMax, shSel, blc, tgt;
    logic [19:0] wgt;
    logic [5:0] pmask, sw1, sw2;
    logic [15:0] pitch;
    logic [7:0] hPix, vLine, gain, frmCnt;
    logic [3:0] hCell, vCell;
    logic pready, pslverr;
    logic [31:0] prdata;
    logic marker, portX, drvOff, autoRun, gainHold, shutFixed, shut100;
    logic blcEn, blcFixed;
    logic [7:0] gainCeil, gainFloor, speedOut;
    logic [11:0] shutCode;
  } ewc_state_t;
endpackage

// file: ewc_top.sv
/*
  Exposure window control: detection grid and area windows, window
  markers and port X window output, exposure mode settings and a simple
  gain loop, all behind an APB slave. Assumes the video pipeline and the
  luminance average share clk; switch inputs are asynchronous pins.
*/
`timescale 1ns/1ps
`include "ewc_regs.svh"
module ewc_top
  import ewc_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // video timing and luminance
  input wire logic frameStart,
  input wire logic lineStart,
  input wire logic pixelActive,
  input wire logic mirrorFlag,
  input wire logic [7:0] lumaAvg,
  // port x and switches
  input wire logic portDriverValue,
  input wire logic [5:0] switchPins,
  output logic portX,
  output logic portDriverOff,
  output logic windowMarker,
  // exposure control
  output logic autoExposureRun,
  output logic [7:0] gainValue,
  output logic [7:0] gainCeiling,
  output logic [7:0] gainFloorOut,
  output logic [7:0] exposureSpeed,
  output logic fixedShutter,
  output logic [11:0] shutterCode,
  output logic shutterHundredth,
  output logic backlightEnable,
  output logic backlightFixedGain,
  output logic [19:0] areaWeights
);
  ewc_state_t s_reg, s_next;

  function automatic logic inSpan(input logic [3:0] c,
                                  input logic [3:0] st,
                                  input logic [3:0] len);
    logic [4:0] en;
    en = {1'b0, st} + {1'b0, len};
    inSpan = ({1'b0, c} >= {1'b0, st}) && ({1'b0, c} < en);
  endfunction

  function automatic logic [3:0] cellStep(input logic [3:0] c);
    cellStep = (c == `EWC_GRID_LAST) ? c : c + 4'h1;
  endfunction

  logic [3:0] hStart, vStart, hLen, vLen;
  logic inH, inV, inBefH, inBefV;
  logic [4:0] areaHit;
  logic inSel;
  logic [5:0] modeEff;
  logic [7:0] ceilSel;
  logic [7:0] expmEff, flcmEff;
  logic setup;

  always_comb begin
    hStart = mirrorFlag ? s_reg.stM[3:0] : s_reg.stN[3:0];
    vStart = s_reg.stN[7:4];
    hLen = s_reg.size[3:0];
    vLen = s_reg.size[7:4];
    inH = inSpan(s_reg.hCell, hStart, hLen);
    inV = inSpan(s_reg.vCell, vStart, vLen);
    inBefH = s_reg.hCell < hStart;
    inBefV = s_reg.vCell < vStart;
    // areas 0..3 ring area 4: top, bottom, left, right bands
    areaHit[4] = inH && inV;
    areaHit[0] = inBefV;
    areaHit[1] = !inBefV && !inV;
    areaHit[2] = inV && inBefH;
    areaHit[3] = inV && !inBefH && !inH;
    inSel = 1'b0;
    if (s_reg.disp[3:1] >= `EWC_SEL_A0 && s_reg.disp[3:1] <= `EWC_SEL_A4)
      inSel = areaHit[s_reg.disp[3:1] - `EWC_SEL_A0];
    if (s_reg.disp[`EWC_F_FULL])
      inSel = 1'b1;
  end

  // switches override register bits where the port mask selects them
  always_comb begin
    modeEff = {s_reg.expm[`EWC_F_SHUT], s_reg.expm[`EWC_F_MANUAL_EXPOSURE_SELECT],
               s_reg.expm[`EWC_F_GSEL], s_reg.flcm[`EWC_F_NFLC],
               s_reg.expm[`EWC_F_EXPOSURE_REFERENCE_SELECT], s_reg.expm[`EWC_F_BACKLIGHT_COMP_DISABLE]};
    modeEff = (modeEff & ~s_reg.pmask) | (s_reg.sw2 & s_reg.pmask);
    expmEff = s_reg.expm;
    expmEff[`EWC_F_BACKLIGHT_COMP_DISABLE] = modeEff[0];
    expmEff[`EWC_F_EXPOSURE_REFERENCE_SELECT] = modeEff[1];
    expmEff[`EWC_F_GSEL] = modeEff[3];
    expmEff[`EWC_F_MANUAL_EXPOSURE_SELECT] = modeEff[4];
    expmEff[`EWC_F_SHUT] = modeEff[5];
    flcmEff = s_reg.flcm;
    flcmEff[`EWC_F_NFLC] = modeEff[2];
    ceilSel = expmEff[`EWC_F_GSEL] ? s_reg.gMaxH : s_reg.gMaxL;
  end

  assign setup = psel && !penable;

  always_comb begin
    s_next = s_reg;
    s_next.sw1 = switchPins;
    s_next.sw2 = s_reg.sw1;
    // apb: answered in the first access cycle
    s_next.pready = setup;
    s_next.pslverr = 1'b0;
    s_next.prdata = 32'h0;
    if (setup) begin
      case (paddr)
        `EWC_A_DISP: s_next.prdata[7:0] = s_reg.disp;
        `EWC_A_ST_N: s_next.prdata[7:0] = s_reg.stN;
        `EWC_A_ST_M: s_next.prdata[7:0] = s_reg.stM;
        `EWC_A_SIZE: s_next.prdata[7:0] = s_reg.size;
        `EWC_A_EXPM: s_next.prdata[7:0] = s_reg.expm;
        `EWC_A_FLCM: s_next.prdata[7:0] = s_reg.flcm;
        `EWC_A_SPD: s_next.prdata[7:0] = s_reg.spd;
        `EWC_A_GMAXL: s_next.prdata[7:0] = s_reg.gMaxL;
        `EWC_A_GMAXH: s_next.prdata[7:0] = s_reg.gMaxH;
        `EWC_A_GMIN: s_next.prdata[7:0] = s_reg.gMin;
        `EWC_A_SHMAX: s_next.prdata[7:0] = s_reg.shMax;
        `EWC_A_SHSEL: s_next.prdata[7:0] = s_reg.shSel;
        `EWC_A_BLC: s_next.prdata[7:0] = s_reg.blc;
        `EWC_A_WGT: s_next.prdata[19:0] = s_reg.wgt;
        `EWC_A_PMASK: s_next.prdata[5:0] = s_reg.pmask;
        `EWC_A_PITCH: s_next.prdata[15:0] = s_reg.pitch;
        `EWC_A_TGT: s_next.prdata[7:0] = s_reg.tgt;
        `EWC_A_STAT: s_next.prdata[23:0] = {s_reg.gain, s_reg.sw2,
                                            inSel, 1'b0,
                                            s_reg.vCell, s_reg.hCell};
        default: s_next.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && s_reg.pready && pwrite) begin
      case (paddr)
        `EWC_A_DISP: s_next.disp = pwdata[7:0];
        `EWC_A_ST_N: s_next.stN = pwdata[7:0];
        `EWC_A_ST_M: s_next.stM = pwdata[7:0];
        `EWC_A_SIZE: s_next.size = pwdata[7:0];
        `EWC_A_EXPM: s_next.expm = pwdata[7:0];
        `EWC_A_FLCM: s_next.flcm = pwdata[7:0];
        `EWC_A_SPD: s_next.spd = pwdata[7:0];
        `EWC_A_GMAXL: s_next.gMaxL = pwdata[7:0];
        `EWC_A_GMAXH: s_next.gMaxH = pwdata[7:0];
        `EWC_A_GMIN: s_next.gMin = pwdata[7:0];
        `EWC_A_SHMAX: s_next.shMax = pwdata[7:0];
        `EWC_A_SHSEL: s_next.shSel = pwdata[7:0];
        `EWC_A_BLC: s_next.blc = pwdata[7:0];
        `EWC_A_WGT: s_next.wgt = pwdata[19:0];
        `EWC_A_PMASK: s_next.pmask = pwdata[5:0];
        `EWC_A_PITCH: s_next.pitch = pwdata[15:0];
        `EWC_A_TGT: s_next.tgt = pwdata[7:0];
        default: s_next.tgt = s_reg.tgt;
      endcase
    end
    // grid counters; cells saturate at the last of fifteen
    if (frameStart) begin
      s_next.vCell = 4'h0;
      s_next.vLine = 8'h0;
    end else if (lineStart) begin
      if (s_reg.vLine >= s_reg.pitch[15:8] - 8'h1) begin
        s_next.vLine = 8'h0;
        s_next.vCell = cellStep(s_reg.vCell);
      end else
        s_next.vLine = s_reg.vLine + 8'h1;
    end
    if (frameStart || lineStart) begin
      s_next.hCell = 4'h0;
      s_next.hPix = 8'h0;
    end else if (pixelActive) begin
      if (s_reg.hPix >= s_reg.pitch[7:0] - 8'h1) begin
        s_next.hPix = 8'h0;
        s_next.hCell = cellStep(s_reg.hCell);
      end else
        s_next.hPix = s_reg.hPix + 8'h1;
    end
    s_next.marker = s_reg.disp[`EWC_F_MK] && inSel && pixelActive;
    s_next.drvOff = s_reg.disp[`EWC_F_WOUT];
    s_next.portX = s_reg.disp[`EWC_F_WOUT] ? inSel
                                            : portDriverValue;
    // exposure mode outputs
    s_next.autoRun = !expmEff[`EWC_F_MANUAL_EXPOSURE_SELECT];
    s_next.gainCeil = ceilSel;
    s_next.gainFloor = s_reg.gMin;
    s_next.speedOut = s_reg.spd;
    s_next.shutFixed = !expmEff[`EWC_F_MANUAL_EXPOSURE_SELECT] && expmEff[`EWC_F_SHUT];
    s_next.shutCode = {flcmEff[`EWC_F_LOW_SPEED_SHUTTER_LIMITER], s_reg.shMax,
                       s_reg.shSel[4:2]};
    s_next.shut100 = s_next.shutFixed && flcmEff[`EWC_F_LOW_SPEED_SHUTTER_LIMITER] &&
                     s_reg.shMax == `EWC_RST_MAX &&
                     s_reg.shSel[4:2] == 3'h0;
    s_next.blcEn = !expmEff[`EWC_F_BACKLIGHT_COMP_DISABLE];
    s_next.blcFixed = s_reg.blc[`EWC_F_BACKLIGHT_METHOD_SELECT];
    // gain loop: one step every spd+1 frames, so larger is slower
    if (frameStart && !expmEff[`EWC_F_MANUAL_EXPOSURE_SELECT]) begin
      if (s_reg.frmCnt >= s_reg.spd) begin
        s_next.frmCnt = 8'h0;
        if (lumaAvg < s_reg.tgt && s_reg.gain < ceilSel)
          s_next.gain = s_reg.gain + 8'h1;
        else if (lumaAvg > s_reg.tgt && s_reg.gain > s_reg.gMin)
          s_next.gain = s_reg.gain - 8'h1;
      end else
        s_next.frmCnt = s_reg.frmCnt + 8'h1;
    end
    // clamp every cycle; floor applied last so it always holds
    if (s_next.gain > ceilSel)
      s_next.gain = ceilSel;
    if (s_next.gain < s_reg.gMin)
      s_next.gain = s_reg.gMin;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.stN <= `EWC_RST_A4;
      s_reg.stM <= `EWC_RST_A4;
      s_reg.size <= `EWC_RST_A4;
      s_reg.spd <= `EWC_RST_SPD;
      s_reg.gMaxL <= `EWC_RST_MAX;
      s_reg.gMaxH <= `EWC_RST_MAX;
      s_reg.shMax <= `EWC_RST_MAX;
      s_reg.pitch <= `EWC_RST_PITCH;
      s_reg.tgt <= `EWC_RST_TGT;
      s_reg.autoRun <= 1'b1;
      s_reg.blcEn <= 1'b1;
      s_reg.gainCeil <= `EWC_RST_MAX;
      s_reg.speedOut <= `EWC_RST_SPD;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign prdata = s_reg.prdata;
  assign portX = s_reg.portX;
  assign portDriverOff = s_reg.drvOff;
  assign windowMarker = s_reg.marker;
  assign autoExposureRun = s_reg.autoRun;
  assign gainValue = s_reg.gain;
  assign gainCeiling = s_reg.gainCeil;
  assign gainFloorOut = s_reg.gainFloor;
  assign exposureSpeed = s_reg.speedOut;
  assign fixedShutter = s_reg.shutFixed;
  assign shutterCode = s_reg.shutCode;
  assign shutterHundredth = s_reg.shut100;
  assign backlightEnable = s_reg.blcEn;
  assign backlightFixedGain = s_reg.blcFixed;
  assign areaWeights = s_reg.wgt;

  AST_PORTX_WINDOW: assert property (@(posedge clk) disable iff (rst)
    ce && s_reg.disp[`EWC_F_WOUT] |=> portX == $past(inSel))
    else $error("port x does not follow the selected window");
  AST_DRIVER_OFF: assert property (@(posedge clk) disable iff (rst)
    ce && s_reg.disp[`EWC_F_WOUT] |=> portDriverOff && $past(ce))
    else $error("port driver not disabled during window output");
  AST_SEL_NONE: assert property (@(posedge clk) disable iff (rst)
    ce && s_reg.disp[`EWC_F_WOUT] && !s_reg.disp[`EWC_F_FULL] &&
    (s_reg.disp[3:1] == 3'h0 || s_reg.disp[3:1] > `EWC_SEL_A4)
    |=> !portX)
    else $error("window shown for a no-window selector");
  AST_AREA_FOUR: assert property (@(posedge clk) disable iff (rst)
    areaHit[4] |-> s_reg.hCell >= hStart && s_reg.vCell >= vStart &&
    !areaHit[0] && !areaHit[1] && !areaHit[2] && !areaHit[3])
    else $error("area four overlaps another area");
  AST_MIRROR: assert property (@(posedge clk) disable iff (rst)
    mirrorFlag && s_reg.hCell < s_reg.stM[3:0] |-> !inH)
    else $error("mirror start not used for horizontal window");
  AST_GAIN_FLOOR: assert property (@(posedge clk) disable iff (rst)
    ce ##1 ce |-> gainValue >= $past(s_reg.gMin))
    else $error("gain below the floor");
  AST_GAIN_CEIL: assert property (@(posedge clk) disable iff (rst)
    ce && ceilSel >= s_reg.gMin |=> gainValue <= $past(ceilSel))
    else $error("gain above the selected ceiling");
  AST_MANUAL_HOLD: assert property (@(posedge clk) disable iff (rst)
    ce && expmEff[`EWC_F_MANUAL_EXPOSURE_SELECT] && s_reg.gain <= ceilSel &&
    s_reg.gain >= s_reg.gMin && $stable(s_reg.gMin) |=> $stable(gainValue))
    else $error("gain moved in manual exposure");
  AST_SHUT_100: assert property (@(posedge clk) disable iff (rst)
    ce && !expmEff[`EWC_F_MANUAL_EXPOSURE_SELECT] && expmEff[`EWC_F_SHUT] &&
    flcmEff[`EWC_F_LOW_SPEED_SHUTTER_LIMITER] && s_reg.shMax == `EWC_RST_MAX &&
    s_reg.shSel[4:2] == 3'h0 |=> shutterHundredth)
    else $error("1/100 s setting not recognised");
  AST_BLC: assert property (@(posedge clk) disable iff (rst)
    ce |=> backlightEnable == !$past(expmEff[`EWC_F_BACKLIGHT_COMP_DISABLE]))
    else $error("backlight enable mismatch");
  AST_APB_READY: assert property (@(posedge clk) disable iff (rst)
    ce && setup ##1 ce |-> pready)
    else $error("apb access not answered");

  COV_WINDOW_OUT: cover property (@(posedge clk) disable iff (rst)
    portX && portDriverOff);
  COV_MARKER: cover property (@(posedge clk) disable iff (rst)
    windowMarker);
  COV_GAIN_UP: cover property (@(posedge clk) disable iff (rst)
    ce && gainValue > $past(gainValue));
endmodule

// file: ewc_video_model.sv
/*
  Video pipeline model for the exposure window block: frame and line
  pulses and bursts of active pixels. Assumes the block samples them on
  the rising edge of the clock it shares with this model.
*/
`timescale 1ns/1ps
module ewc_video_model (
  // clock
  input wire logic clk,
  // timing towards the block
  output logic frameStart,
  output logic lineStart,
  output logic pixelActive
);
  initial begin
    frameStart = 1'b0;
    lineStart = 1'b0;
    pixelActive = 1'b0;
  end
  // a pulse lasts one clock, never longer, as the real pipeline makes it
  task automatic pulse(input logic fr);
    @(posedge clk);
    if (fr)
      frameStart <= 1'b1;
    else
      lineStart <= 1'b1;
    @(posedge clk);
    frameStart <= 1'b0;
    lineStart <= 1'b0;
  endtask
  task automatic pixels(input int n);
    repeat (n) begin
      @(posedge clk);
      pixelActive <= 1'b1;
    end
    @(posedge clk);
    pixelActive <= 1'b0;
  endtask
endmodule

// file: exposure_window_control_test.sv
/*
  Self-checking bench for the exposure window block: registers over APB,
  window selection on port X, exposure flags, switches and gain loop.
  Assumes ewc_video_model as the video side; pitch is cut to 2x2.
*/
`timescale 1ns/1ps
`include "ewc_regs.svh"
module exposure_window_control_test
  import ewc_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdata;
  logic rerr, mirrorFlag = 1'b0, portDriverValue = 1'b0;
  logic [7:0] lumaAvg = 8'h80;
  logic [5:0] switchPins = 6'h00;
  logic pready, pslverr, frameStart, lineStart, pixelActive, portX;
  logic portDriverOff, windowMarker, autoExposureRun, fixedShutter;
  logic shutterHundredth, backlightEnable, backlightFixedGain;
  logic [31:0] prdata;
  logic [7:0] gainValue, gainCeiling, gainFloorOut, exposureSpeed;
  logic [11:0] shutterCode;
  logic [19:0] areaWeights;
  int numErrors = 0, cmpCount = 0, cycles = 0, markCnt = 0;
  logic [31:0] rstv [17] = '{32'h0, 32'h55, 32'h55, 32'h55, 32'h0, 32'h0,
    32'h4, 32'hFF, 32'hFF, 32'h0, 32'hFF, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h1010, 32'h80};
  logic [31:0] msk [17] = '{32'h9F, 32'hFF, 32'hFF, 32'hFF, 32'h5D, 32'h3,
    32'hFF, 32'hFF, 32'hFF, 32'hFF, 32'hFF, 32'h1C, 32'h1, 32'hFFFFF,
    32'h3F, 32'hFFFF, 32'hFF};

  ewc_top ewc_top_i (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .frameStart(frameStart), .lineStart(lineStart),
    .pixelActive(pixelActive), .mirrorFlag(mirrorFlag),
    .lumaAvg(lumaAvg), .portDriverValue(portDriverValue),
    .switchPins(switchPins), .portX(portX), .portDriverOff(portDriverOff),
    .windowMarker(windowMarker), .autoExposureRun(autoExposureRun),
    .gainValue(gainValue), .gainCeiling(gainCeiling),
    .gainFloorOut(gainFloorOut), .exposureSpeed(exposureSpeed),
    .fixedShutter(fixedShutter), .shutterCode(shutterCode),
    .shutterHundredth(shutterHundredth),
    .backlightEnable(backlightEnable),
    .backlightFixedGain(backlightFixedGain), .areaWeights(areaWeights));
  ewc_video_model ewc_video_model_i (.clk(clk), .frameStart(frameStart),
    .lineStart(lineStart), .pixelActive(pixelActive));

  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (windowMarker === 1'b1)
      markCnt <= markCnt + 1;
    // over three times the expected run length
    if (cycles == 80000) begin
      numErrors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("errors %0d comparisons %0d", numErrors, cmpCount);
    if (numErrors == 0 && cmpCount > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] got, exp);
    cmpCount++;
    if (got !== exp) begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // the slave may add wait states; pready or the bound of 20 cycles ends the wait
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      numErrors++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask

  function automatic logic inWin(input logic [7:0] d, sn, sm, sz,
                                 input logic mir, input logic [3:0] h, v);
    logic [4:0] hs, vs, he, ve;
    logic rows;
    hs = mir ? sm[3:0] : sn[3:0];
    vs = {1'b0, sn[7:4]};
    he = hs + sz[3:0];
    ve = vs + sz[7:4];
    rows = (v >= vs) && (v < ve);
    if (d[4])
      return 1'b1;
    case (d[3:1])
      3'h1: return v < vs;
      3'h2: return v >= ve;
      3'h3: return rows && h < hs;
      3'h4: return rows && h >= he;
      3'h5: return rows && h >= hs && h < he;
      default: return 1'b0;
    endcase
  endfunction

  task automatic expo();
    logic [7:0] f, fl, gl, gh, fm, sm, sp;
    logic [2:0] ss;
    logic b;
    logic [19:0] w;
    for (int i = 0; i < 16; i++) begin
      f = 8'($urandom) & 8'h5D;
      fl = 8'($urandom) & 8'h03;
      fm = 8'($urandom % 64);
      gl = 8'(64 + $urandom % 192);
      gh = 8'(64 + $urandom % 192);
      sm = i[0] ? 8'($urandom) : 8'hFF;
      ss = 3'($urandom);
      b = 1'($urandom);
      sp = 8'($urandom);
      w = 20'($urandom);
      if (i == 0) begin
        f = 8'h40;
        fl = 8'h02;
        ss = 3'h0;
      end
      wr(`EWC_A_EXPM, f);
      wr(`EWC_A_FLCM, fl);
      wr(`EWC_A_GMAXL, gl);
      wr(`EWC_A_GMAXH, gh);
      wr(`EWC_A_GMIN, fm);
      wr(`EWC_A_SHMAX, sm);
      wr(`EWC_A_SHSEL, 32'({ss, 2'b00}));
      wr(`EWC_A_BLC, b);
      wr(`EWC_A_SPD, sp);
      wr(`EWC_A_WGT, w);
      settle();
      chk("autoRun", autoExposureRun, !f[0]);
      chk("fixedShutter", fixedShutter, !f[0] & f[6]);
      chk("gainCeiling", gainCeiling, f[4] ? gh : gl);
      chk("gainFloor", gainFloorOut, fm);
      chk("shutterCode", shutterCode, {fl[1], sm, ss});
      chk("hundredth", shutterHundredth,
          !f[0] & f[6] & fl[1] & (sm == 8'hFF) & (ss == 3'h0));
      chk("blcEnable", backlightEnable, !f[2]);
      if (!f[2])
        chk("blcFixed", backlightFixedGain, b);
      chk("speed", exposureSpeed, sp);
      chk("weights", areaWeights, w);
    end
    wr(`EWC_A_PMASK, 32'h3F);
    for (int i = 0; i < 8; i++) begin
      switchPins <= 6'($urandom);
      repeat (5) @(posedge clk);
      rd(`EWC_A_STAT);
      chk("switches", rdata[15:10], switchPins);
      chk("swRun", autoExposureRun, !switchPins[4]);
      chk("swShut", fixedShutter, !switchPins[4] & switchPins[5]);
      chk("swBlc", backlightEnable, !switchPins[0]);
      chk("swCeil", gainCeiling, switchPins[3] ? gh : gl);
    end
    wr(`EWC_A_PMASK, 32'h0);
    wr(`EWC_A_EXPM, 32'h0);
  endtask

  task automatic scan(input logic [7:0] disp, stN, stM, sz);
    int p, n;
    logic e, anyIn;
    anyIn = 1'b0;
    wr(`EWC_A_DISP, disp);
    wr(`EWC_A_ST_N, stN);
    wr(`EWC_A_ST_M, stM);
    wr(`EWC_A_SIZE, sz);
    mirrorFlag <= 1'($urandom);
    portDriverValue <= 1'($urandom);
    markCnt = 0;
    ewc_video_model_i.pulse(1'b1);
    for (int l = 0; l < 30; l++) begin
      ewc_video_model_i.pulse(1'b0);
      p = 0;
      while (p < 30) begin
        n = 1 + $urandom % 5;
        ewc_video_model_i.pixels(n);
        p += n;
        rd(`EWC_A_STAT);
        chk("hCell", rdata[3:0], (p / 2 > 14) ? 14 : p / 2);
        e = inWin(disp, stN, stM, sz, mirrorFlag, rdata[3:0], rdata[7:4]);
        anyIn |= e;
        chk("inSel", rdata[9], e);
        chk("portX", portX, disp[7] ? e : portDriverValue);
        chk("driverOff", portDriverOff, disp[7]);
      end
    end
    chk("vCell", rdata[7:4], 14);
    // the status reads skip cells, so widen to every cell the pixels crossed
    for (int hh = 0; hh < 15; hh++)
      for (int vv = 0; vv < 15; vv++)
        anyIn |= inWin(disp, stN, stM, sz, mirrorFlag, 4'(hh), 4'(vv));
    chk("marker", markCnt != 0, disp[0] & anyIn);
  endtask

  task automatic gainRun();
    logic [7:0] g;
    int cnt;
    wr(`EWC_A_GMIN, 8'h10);
    wr(`EWC_A_GMAXL, 8'h10);
    wr(`EWC_A_GMAXL, 8'h14);
    wr(`EWC_A_SPD, 32'h0);
    lumaAvg <= 8'h00;
    settle();
    chk("gainClamp", gainValue, 8'h10);
    g = 8'h10;
    cnt = 0;
    for (int k = 0; k < 24; k++) begin
      if (k == 6)
        lumaAvg <= 8'hFF;
      if (k == 12) begin
        lumaAvg <= 8'h00;
        wr(`EWC_A_SPD, 32'h1);
      end
      if (k == 20)
        wr(`EWC_A_EXPM, 32'h1);
      ewc_video_model_i.pulse(1'b1);
      if (k < 20) begin
        if (cnt >= (k >= 12 ? 1 : 0)) begin
          cnt = 0;
          if (lumaAvg < 8'h80 && g < 8'h14)
            g++;
          else if (lumaAvg > 8'h80 && g > 8'h10)
            g--;
        end else
          cnt++;
      end
      settle();
      chk("gain", gainValue, g);
    end
  endtask

  initial begin
    logic [31:0] d;
    logic [3:0] v;
    void'($urandom(32'hF9C8C44E));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("runAtReset", autoExposureRun, 1'b1);
    chk("ceilAtReset", gainCeiling, 8'hFF);
    chk("speedAtReset", exposureSpeed, 8'h04);
    for (int i = 0; i < 17; i++) begin
      rd(12'(i * 4));
      chk("resetValue", rdata, rstv[i]);
    end
    rd(12'h048);
    chk("unmappedErr", rerr, 1'b1);
    chk("unmappedData", rdata, 32'h0);
    wr(12'h048, 32'hFFFFFFFF);
    chk("unmappedWrErr", rerr, 1'b1);
    for (int i = 0; i < 17; i++) begin
      d = $urandom & msk[i];
      wr(12'(i * 4), d);
      rd(12'(i * 4));
      chk("readback", rdata, d);
    end
    wr(`EWC_A_PITCH, 32'h0202);
    // undo the random mask and target left by the readback pass
    wr(`EWC_A_PMASK, 32'h0);
    wr(`EWC_A_TGT, 32'h80);
    expo();
    for (int s = 0; s < 10; s++) begin
      v = 4'($urandom % 15);
      scan(8'((s < 8 ? s * 2 : 8'h10) | ($urandom & 8'h81)),
           {v, 4'($urandom % 15)}, {v, 4'($urandom % 15)},
           8'($urandom));
    end
    gainRun();
    summarize();
  end
endmodule
